// ---- logic/aeqcfg_pkg.sv ----
// Purpose: shared constants for the equalization configuration bank
// Assumes: byte-wide registers behind a serial management decoder
// Notes:   offsets, fields, resets and step sizes live here; the checks repeat some as literals
package aeqcfg_pkg;

    // register offsets
    localparam logic [7:0] OFS_GENERAL  = 8'h0A;
    localparam logic [7:0] OFS_CTRL     = 8'h1C;
    localparam logic [7:0] OFS_TRIM     = 8'h1D;
    localparam logic [7:0] OFS_LONG     = 8'h1E;
    localparam logic [7:0] OFS_CONN     = 8'h20;
    localparam logic [7:0] OFS_HOST     = 8'h21;
    localparam logic [7:0] OFS_STAT1    = 8'h24;
    localparam logic [7:0] OFS_STAT2    = 8'h25;

    // reset values
    localparam logic [7:0] RST_GENERAL  = 8'h00;
    localparam logic [7:0] RST_CTRL     = 8'h85;
    localparam logic [7:0] RST_TRIM     = 8'h10;
    localparam logic [7:0] RST_LONG     = 8'h77;
    localparam logic [7:0] RST_CONN     = 8'h00;
    localparam logic [7:0] RST_HOST     = 8'h00;

    // field positions
    localparam int MAX_HI    = 7;
    localparam int MAX_LO    = 4;
    localparam int IDLE_BIT  = 3;
    localparam int MODE_HI   = 2;
    localparam int MODE_LO   = 1;
    localparam int EN_BIT    = 0;
    localparam int SIGN_BIT  = 7;
    localparam int RSVD_BIT  = 6;
    localparam int WIN_HI    = 5;
    localparam int WIN_LO    = 3;
    localparam int MAG_HI    = 2;
    localparam int MAG_LO    = 0;
    localparam int SRC_BIT   = 4;
    localparam int FLAG_BIT  = 7;
    localparam int NIB2_HI   = 7;
    localparam int NIB2_LO   = 4;
    localparam int NIB1_HI   = 3;
    localparam int NIB1_LO   = 0;

    // writable bits of the limits/trim register
    localparam logic [7:0] TRIM_WMASK   = 8'hBF;

    // fast threshold window step
    localparam logic [5:0] WIN_STEP_MV  = 6'h28;

    // eq code range
    localparam logic [3:0] EQ_MAX       = 4'hF;

    typedef enum logic [1:0] {
        MODE_FAST,
        MODE_FULL_EVERY,
        MODE_FULL_ALG2,
        MODE_FULL_FIRST
    } aeqcfg_mode_t;

endpackage

// ---- logic/aeqcfg_strap_latch.sv ----
// Purpose: capture a strap code once after reset release
// Assumes: strap inputs are stable around reset release
// Notes:   async reset loads a constant; the pin is sampled by a clock
`timescale 1ns/1ps
module aeqcfg_strap_latch (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] strap,
    output logic      [3:0] code
);
    logic       taken_ff;
    logic [3:0] code_ff;

    // first edge after release takes the pins, later edges hold
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            taken_ff <= 1'b0;
            code_ff  <= 4'h0;
        end else if (!taken_ff) begin
            taken_ff <= 1'b1;
            code_ff  <= strap;
        end
    end

    assign code = code_ff;
endmodule

// ---- logic/aeqcfg_port_eq.sv ----
// Purpose: pick the connector receiver eq code for one port
// Assumes: adaptation result and channel length come from the analog side
// Notes:   trimmed result is clamped to the legal code range
`timescale 1ns/1ps
module aeqcfg_port_eq (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       adapt_en,
    input  wire logic [1:0] mode,
    input  wire logic [3:0] short_code,
    input  wire logic [3:0] long_code,
    input  wire logic       long_detect,
    input  wire logic [3:0] full_result,
    input  wire logic       trim_sign,
    input  wire logic [2:0] trim_mag,
    output logic      [3:0] eq_code,
    output logic            long_flag
);
    logic        fast;
    logic [5:0]  ofs;
    logic [5:0]  sum;
    logic [3:0]  trimmed;
    logic [3:0]  eq_ff;
    logic        flag_ff;

    assign fast = (mode == aeqcfg_pkg::MODE_FAST);

    // negative trim is magnitude minus eight, sign extended
    assign ofs = trim_sign ? {3'b111, trim_mag}
                           : {3'b000, trim_mag};
    assign sum = {2'b00, full_result} + ofs;

    // clamp underflow to zero and overflow to the top code
    always_comb begin
        if (sum[5])
            trimmed = 4'h0;
        else if (sum[4])
            trimmed = aeqcfg_pkg::EQ_MAX;
        else
            trimmed = sum[3:0];
    end

    // source of the receiver code
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            eq_ff <= 4'h0;
        else if (!adapt_en)
            eq_ff <= short_code;
        else if (!fast)
            eq_ff <= trimmed;
        else if (long_detect)
            eq_ff <= long_code;
        else
            eq_ff <= short_code;
    end

    // channel length flag, zero unless fast adaptation runs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            flag_ff <= 1'b0;
        else
            flag_ff <= adapt_en & fast & long_detect;
    end

    assign eq_code   = eq_ff;
    assign long_flag = flag_ff;
endmodule

// ---- logic/aeqcfg_regs.sv ----
// Purpose: receiver equalization configuration bank
// Assumes: a serial management decoder presents byte reads and writes
// Notes:   read data returns one cycle after the read strobe
//
// What this block does
// - max code field bounds full adaptation search
// - idle redirect bit picks U1 or U3
// - mode field selects fast or full algorithm
// - bit 0 enables adaptation, resets enabled
// - trim sign bit: zero positive, one negative
// - window code sets threshold in 40 mV steps
// - negative trim subtracts eight minus code
// - trim applies only in full adaptation
// - fast long channel uses long codes
// - fast short channel uses connector codes
// - adaptation off: connector nibbles drive receivers
// - software source off: connector nibbles follow straps
// - software source on: writes set connector nibbles
// - software source off: host nibbles follow straps
// - software source on: writes drive host receivers
// - general bit 4 selects straps or registers
// - status bit 7 shows long code in use
`timescale 1ns/1ps
module aeqcfg_regs (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic [3:0] connector_eq_straps,
    input  wire logic [3:0] host_eq_straps,
    input  wire logic       elec_idle_detect,
    input  wire logic [1:0] long_channel_detect,
    input  wire logic [3:0] full_result_1,
    input  wire logic [3:0] full_result_2,
    output logic      [3:0] connector_receiver_1_eq,
    output logic      [3:0] connector_receiver_2_eq,
    output logic      [3:0] host_receiver_1_eq,
    output logic      [3:0] host_receiver_2_eq,
    output logic            adapt_enable,
    output logic      [1:0] adapt_mode_select,
    output logic      [3:0] full_adapt_max_code,
    output logic      [2:0] fast_threshold_window,
    output logic      [8:0] fast_threshold_mv,
    output logic            enter_u1,
    output logic            enter_u3
);
    // register storage
    logic [7:0] general_ff;
    logic [7:0] ctrl_ff;
    logic [7:0] trim_ff;
    logic [7:0] long_ff;
    logic [7:0] conn_ff;
    logic [7:0] host_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    // derived outputs
    logic [3:0] host1_ff;
    logic [3:0] host2_ff;
    logic       en_ff;
    logic [1:0] mode_ff;
    logic [3:0] max_ff;
    logic [2:0] win_ff;
    logic [8:0] mv_ff;
    logic [8:0] nxt_mv;
    logic       idle_d_ff;
    logic       u1_ff;
    logic       u3_ff;

    // strap samples and per-port results
    logic [3:0] conn_strap;
    logic [3:0] host_strap;
    logic [3:0] conn1_eq;
    logic [3:0] conn2_eq;
    logic       flag1;
    logic       flag2;

    // decoded write strobes
    logic       wr_general;
    logic       wr_ctrl;
    logic       wr_trim;
    logic       wr_long;
    logic       wr_conn;
    logic       wr_host;
    logic       sw_source;
    logic       idle_rise;

    assign wr_general = reg_wr_en
                        & (reg_addr == aeqcfg_pkg::OFS_GENERAL);
    assign wr_ctrl    = reg_wr_en
                        & (reg_addr == aeqcfg_pkg::OFS_CTRL);
    assign wr_trim    = reg_wr_en
                        & (reg_addr == aeqcfg_pkg::OFS_TRIM);
    assign wr_long    = reg_wr_en
                        & (reg_addr == aeqcfg_pkg::OFS_LONG);
    assign wr_conn    = reg_wr_en
                        & (reg_addr == aeqcfg_pkg::OFS_CONN);
    assign wr_host    = reg_wr_en
                        & (reg_addr == aeqcfg_pkg::OFS_HOST);

    assign sw_source  = general_ff[aeqcfg_pkg::SRC_BIT];

    // strap capture, one each for connector and host side
    aeqcfg_strap_latch u_conn_strap (
        .clk   (clk),
        .rst_n (rst_n),
        .strap (connector_eq_straps),
        .code  (conn_strap)
    );

    aeqcfg_strap_latch u_host_strap (
        .clk   (clk),
        .rst_n (rst_n),
        .strap (host_eq_straps),
        .code  (host_strap)
    );

    // general register: only the eq source bit is held here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            general_ff <= aeqcfg_pkg::RST_GENERAL;
        else if (wr_general)
            general_ff[aeqcfg_pkg::SRC_BIT] <=
                reg_wdata[aeqcfg_pkg::SRC_BIT];
    end

    // main adaptive control register, fully writable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            ctrl_ff <= aeqcfg_pkg::RST_CTRL;
        else if (wr_ctrl)
            ctrl_ff <= reg_wdata;
    end

    // limits and trim; the reserved bit is masked off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            trim_ff <= aeqcfg_pkg::RST_TRIM;
        else if (wr_trim)
            trim_ff <= reg_wdata & aeqcfg_pkg::TRIM_WMASK;
    end

    // long channel codes; values chosen by software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            long_ff <= aeqcfg_pkg::RST_LONG;
        else if (wr_long)
            long_ff <= reg_wdata;
    end

    // connector eq: straps reload it while software is not the
    // source, so a later switch to software starts from the pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            conn_ff <= aeqcfg_pkg::RST_CONN;
        else if (!sw_source)
            conn_ff <= {conn_strap, conn_strap};
        else if (wr_conn)
            conn_ff <= reg_wdata;
    end

    // host eq: same scheme as the connector side
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            host_ff <= aeqcfg_pkg::RST_HOST;
        else if (!sw_source)
            host_ff <= {host_strap, host_strap};
        else if (wr_host)
            host_ff <= reg_wdata;
    end

    // per-port connector receiver code selection
    aeqcfg_port_eq u_port1 (
        .clk         (clk),
        .rst_n       (rst_n),
        .adapt_en    (ctrl_ff[aeqcfg_pkg::EN_BIT]),
        .mode        (ctrl_ff[aeqcfg_pkg::MODE_HI:
                              aeqcfg_pkg::MODE_LO]),
        .short_code  (conn_ff[aeqcfg_pkg::NIB1_HI:
                              aeqcfg_pkg::NIB1_LO]),
        .long_code   (long_ff[aeqcfg_pkg::NIB1_HI:
                              aeqcfg_pkg::NIB1_LO]),
        .long_detect (long_channel_detect[0]),
        .full_result (full_result_1),
        .trim_sign   (trim_ff[aeqcfg_pkg::SIGN_BIT]),
        .trim_mag    (trim_ff[aeqcfg_pkg::MAG_HI:
                              aeqcfg_pkg::MAG_LO]),
        .eq_code     (conn1_eq),
        .long_flag   (flag1)
    );

    aeqcfg_port_eq u_port2 (
        .clk         (clk),
        .rst_n       (rst_n),
        .adapt_en    (ctrl_ff[aeqcfg_pkg::EN_BIT]),
        .mode        (ctrl_ff[aeqcfg_pkg::MODE_HI:
                              aeqcfg_pkg::MODE_LO]),
        .short_code  (conn_ff[aeqcfg_pkg::NIB2_HI:
                              aeqcfg_pkg::NIB2_LO]),
        .long_code   (long_ff[aeqcfg_pkg::NIB2_HI:
                              aeqcfg_pkg::NIB2_LO]),
        .long_detect (long_channel_detect[1]),
        .full_result (full_result_2),
        .trim_sign   (trim_ff[aeqcfg_pkg::SIGN_BIT]),
        .trim_mag    (trim_ff[aeqcfg_pkg::MAG_HI:
                              aeqcfg_pkg::MAG_LO]),
        .eq_code     (conn2_eq),
        .long_flag   (flag2)
    );

    // host receiver codes follow the register one cycle later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            host1_ff <= 4'h0;
            host2_ff <= 4'h0;
        end else begin
            host1_ff <= host_ff[aeqcfg_pkg::NIB1_HI:
                                aeqcfg_pkg::NIB1_LO];
            host2_ff <= host_ff[aeqcfg_pkg::NIB2_HI:
                                aeqcfg_pkg::NIB2_LO];
        end
    end

    // adaptation controls handed to the analog engine
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_ff   <= 1'b0;
            mode_ff <= 2'h0;
            max_ff  <= 4'h0;
        end else begin
            en_ff   <= ctrl_ff[aeqcfg_pkg::EN_BIT];
            mode_ff <= ctrl_ff[aeqcfg_pkg::MODE_HI:
                               aeqcfg_pkg::MODE_LO];
            max_ff  <= ctrl_ff[aeqcfg_pkg::MAX_HI:
                               aeqcfg_pkg::MAX_LO];
        end
    end

    // window in millivolts; widen first so 280 mV does not wrap
    assign nxt_mv = {6'h00, trim_ff[aeqcfg_pkg::WIN_HI:aeqcfg_pkg::WIN_LO]}
                    * {3'h0, aeqcfg_pkg::WIN_STEP_MV};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            win_ff <= 3'h0;
            mv_ff  <= 9'h000;
        end else begin
            win_ff <= trim_ff[aeqcfg_pkg::WIN_HI:
                              aeqcfg_pkg::WIN_LO];
            mv_ff  <= nxt_mv;
        end
    end

    // idle entry: one pulse per rising edge of electrical idle
    assign idle_rise = elec_idle_detect & ~idle_d_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_d_ff <= 1'b0;
            u1_ff     <= 1'b0;
            u3_ff     <= 1'b0;
        end else begin
            idle_d_ff <= elec_idle_detect;
            u1_ff     <= idle_rise
                         & ~ctrl_ff[aeqcfg_pkg::IDLE_BIT];
            u3_ff     <= idle_rise
                         & ctrl_ff[aeqcfg_pkg::IDLE_BIT];
        end
    end

    // read mux; unmapped offsets read as zero
    always_comb begin
        nxt_rdata = 8'h00;
        unique case (reg_addr)
            aeqcfg_pkg::OFS_GENERAL: nxt_rdata = general_ff;
            aeqcfg_pkg::OFS_CTRL:    nxt_rdata = ctrl_ff;
            aeqcfg_pkg::OFS_TRIM:    nxt_rdata = trim_ff;
            aeqcfg_pkg::OFS_LONG:    nxt_rdata = long_ff;
            aeqcfg_pkg::OFS_CONN:    nxt_rdata = conn_ff;
            aeqcfg_pkg::OFS_HOST:    nxt_rdata = host_ff;
            aeqcfg_pkg::OFS_STAT1:
                nxt_rdata[aeqcfg_pkg::FLAG_BIT] = flag1;
            aeqcfg_pkg::OFS_STAT2:
                nxt_rdata[aeqcfg_pkg::FLAG_BIT] = flag2;
            default:                 nxt_rdata = 8'h00;
        endcase
    end

    // read data is held until the next read strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            rdata_ff <= 8'h00;
        else if (reg_rd_en)
            rdata_ff <= nxt_rdata;
    end

    assign reg_rdata               = rdata_ff;
    assign connector_receiver_1_eq = conn1_eq;
    assign connector_receiver_2_eq = conn2_eq;
    assign host_receiver_1_eq      = host1_ff;
    assign host_receiver_2_eq      = host2_ff;
    assign adapt_enable            = en_ff;
    assign adapt_mode_select       = mode_ff;
    assign full_adapt_max_code     = max_ff;
    assign fast_threshold_window   = win_ff;
    assign fast_threshold_mv       = mv_ff;
    assign enter_u1                = u1_ff;
    assign enter_u3                = u3_ff;
endmodule

// ---- verification/aeqcfg_regs_sva.sv ----
// Purpose: port assertions for the eq configuration bank
// Assumes: single clock, rst_n async active low
// Notes:   long code shadow follows host writes
`timescale 1ns/1ps
module aeqcfg_regs_sva (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       reg_wr_en,
    input wire logic       reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       elec_idle_detect,
    input wire logic [1:0] long_channel_detect,
    input wire logic [3:0] connector_receiver_1_eq,
    input wire logic [3:0] connector_receiver_2_eq,
    input wire logic       adapt_enable,
    input wire logic [1:0] adapt_mode_select,
    input wire logic [3:0] full_adapt_max_code,
    input wire logic [2:0] fast_threshold_window,
    input wire logic [8:0] fast_threshold_mv,
    input wire logic       enter_u1,
    input wire logic       enter_u3
);
    logic [7:0] long_sh_ff;
    logic [7:0] long_q_ff;
    logic [1:0] detect_q_ff;
    logic       flag_exp;

    // shadow of the long code register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            long_sh_ff <= aeqcfg_pkg::RST_LONG;
        end else if (reg_wr_en && reg_addr == aeqcfg_pkg::OFS_LONG) begin
            long_sh_ff <= reg_wdata;
        end
    end

    // output stage delays
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            long_q_ff   <= aeqcfg_pkg::RST_LONG;
            detect_q_ff <= 2'h0;
        end else begin
            long_q_ff   <= long_sh_ff;
            detect_q_ff <= long_channel_detect;
        end
    end

    // expected status flag
    assign flag_exp = adapt_enable && adapt_mode_select == 2'h0 &&
                      detect_q_ff[0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_window_mv: assert property (
        fast_threshold_mv == {6'h00, fast_threshold_window} * 9'h028)
        else $error("window millivolts do not match the code");
    chk_ctrl_fields: assert property (
        reg_wr_en && reg_addr == aeqcfg_pkg::OFS_CTRL |-> ##2
        ({full_adapt_max_code, 1'b0, adapt_mode_select, adapt_enable}
         == ($past(reg_wdata, 2) & 8'hF7)))
        else $error("control outputs did not follow the write");
    chk_trim_window: assert property (
        reg_wr_en && reg_addr == aeqcfg_pkg::OFS_TRIM |-> ##2
        ({2'h0, fast_threshold_window, 3'h0} == ($past(reg_wdata, 2) & 8'h38)))
        else $error("window output did not follow the write");
    chk_rsvd_zero: assert property (
        reg_rd_en && reg_addr == aeqcfg_pkg::OFS_TRIM |=> !reg_rdata[6])
        else $error("reserved trim bit read as one");
    chk_idle_cause: assert property (
        enter_u1 || enter_u3 |-> $past(elec_idle_detect) &&
        !$past(elec_idle_detect, 2) && !(enter_u1 && enter_u3))
        else $error("low power entry without an idle rise");
    chk_idle_pulse: assert property (
        $rose(elec_idle_detect) |=> (enter_u1 != enter_u3) ##1
        (!enter_u1 && !enter_u3))
        else $error("idle rise did not give exactly one pulse");
    chk_fast_long: assert property (
        adapt_enable && adapt_mode_select == 2'h0 |->
        (!detect_q_ff[0] || connector_receiver_1_eq == long_q_ff[3:0]) &&
        (!detect_q_ff[1] || connector_receiver_2_eq == long_q_ff[7:4]))
        else $error("long channel code not applied in fast mode");
    chk_status_flag: assert property (
        reg_rd_en && reg_addr == aeqcfg_pkg::OFS_STAT1 |=>
        reg_rdata[7] == $past(flag_exp))
        else $error("channel length status flag wrong");

    cov_fast_long: cover property (flag_exp && detect_q_ff == 2'h3);
    cov_u3_entry: cover property (enter_u3);
    cov_adapt_off: cover property (!adapt_enable);
endmodule

// ---- verification/aeqcfg_host_model.sv ----
// Purpose: serial management host issuing single byte accesses
// Assumes: one strobe pulse per byte, read data valid the cycle after
// Notes:   released bus shows inverted values
`timescale 1ns/1ps
module aeqcfg_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    // idle bus at time zero
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = 8'hFF;
        reg_wdata = 8'hFF;
    end

    // writes are legal at any time
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(posedge clk);
        #1;
        reg_wr_en = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask

    // data taken after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr  = a;
        reg_rd_en = 1'b1;
        @(posedge clk);
        #1;
        reg_rd_en = 1'b0;
        reg_addr  = ~a;
        d         = reg_rdata;
    endtask
endmodule

// ---- verification/testbench.sv ----
// Purpose: self-checking bench for the eq configuration bank
// Assumes: host model issues accesses, bench drives the analog side
// Notes:   full results fixed at 6 and 9 so trim sums are easy to follow
`timescale 1ns/1ps
module testbench;
    logic       clk;
    logic       rst_n;
    logic       reg_wr_en, reg_rd_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v;
    logic [3:0] connector_eq_straps, host_eq_straps;
    logic       elec_idle_detect;
    logic [1:0] long_channel_detect;
    logic [3:0] full_result_1, full_result_2;
    logic [3:0] conn_eq_1, conn_eq_2, host_eq_1, host_eq_2;
    logic       adapt_enable;
    logic [1:0] adapt_mode_select;
    logic [3:0] full_adapt_max_code;
    logic [2:0] fast_threshold_window;
    logic [8:0] fast_threshold_mv;
    logic       enter_u1, enter_u3;
    int         fails, checks, cyc;
    // trim writes, expected codes for results 6 and 9
    localparam logic [7:0] TV [6] = '{8'h12, 8'hD2, 8'h97, 8'h17, 8'h80,
                                      8'hBB};
    localparam logic [3:0] TE1 [6] = '{4'h8, 4'h0, 4'h5, 4'hD, 4'h0, 4'h1};
    localparam logic [3:0] TE2 [6] = '{4'hB, 4'h3, 4'h8, 4'hF, 4'h1, 4'h4};

    aeqcfg_host_model u_aeqcfg_host_model (.clk(clk), .reg_rdata(reg_rdata),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata));

    aeqcfg_regs u_aeqcfg_regs (.clk(clk), .rst_n(rst_n),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .connector_eq_straps(connector_eq_straps),
        .host_eq_straps(host_eq_straps), .elec_idle_detect(elec_idle_detect),
        .long_channel_detect(long_channel_detect),
        .full_result_1(full_result_1), .full_result_2(full_result_2),
        .connector_receiver_1_eq(conn_eq_1),
        .connector_receiver_2_eq(conn_eq_2),
        .host_receiver_1_eq(host_eq_1), .host_receiver_2_eq(host_eq_2),
        .adapt_enable(adapt_enable), .adapt_mode_select(adapt_mode_select),
        .full_adapt_max_code(full_adapt_max_code),
        .fast_threshold_window(fast_threshold_window),
        .fast_threshold_mv(fast_threshold_mv), .enter_u1(enter_u1),
        .enter_u3(enter_u3));

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input string n, input logic [8:0] e,
                       input logic [8:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        u_aeqcfg_host_model.rd(a, rd_v);
        chk($sformatf("read %h", a), {1'b0, e}, {1'b0, rd_v});
    endtask

    // register edge plus output edge
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic wrs(input logic [7:0] a, input logic [7:0] d);
        u_aeqcfg_host_model.wr(a, d);
        settle();
    endtask

    task automatic ceq(input logic [3:0] e1, input logic [3:0] e2);
        chk("connector eq", {1'b0, e2, e1}, {1'b0, conn_eq_2, conn_eq_1});
    endtask

    task automatic heq(input logic [3:0] e1, input logic [3:0] e2);
        chk("host eq", {1'b0, e2, e1}, {1'b0, host_eq_2, host_eq_1});
    endtask

    // a held idle level must give one pulse only
    task automatic idle_chk(input logic u1, input logic u3);
        elec_idle_detect = 1'b1;
        @(posedge clk);
        #1;
        chk("entry pulse", {7'h00, u1, u3}, {7'h00, enter_u1, enter_u3});
        @(posedge clk);
        #1;
        chk("pulse end", 9'h000, {7'h00, enter_u1, enter_u3});
        elec_idle_detect = 1'b0;
    endtask

    task automatic final_report;
        if (fails == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // hang guard; run needs under 1000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        rst_n = 1'b0;
        connector_eq_straps = 4'h5;
        host_eq_straps = 4'hA;
        elec_idle_detect = 1'b0;
        long_channel_detect = 2'h0;
        full_result_1 = 4'h6;
        full_result_2 = 4'h9;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        rchk(aeqcfg_pkg::OFS_GENERAL, aeqcfg_pkg::RST_GENERAL);
        rchk(aeqcfg_pkg::OFS_CTRL, aeqcfg_pkg::RST_CTRL);
        rchk(aeqcfg_pkg::OFS_LONG, aeqcfg_pkg::RST_LONG);
        rchk(aeqcfg_pkg::OFS_CONN, 8'h55);
        rchk(aeqcfg_pkg::OFS_HOST, 8'hAA);
        rchk(8'h40, 8'h00);
        heq(4'hA, 4'hA);
        chk("threshold mv", 9'h050, fast_threshold_mv);
        ceq(4'h6, 4'h9);
        // signed trim in full mode, including clamps and the reserved bit
        for (int i = 0; i < 6; i++) begin
            wrs(aeqcfg_pkg::OFS_TRIM, TV[i]);
            ceq(TE1[i], TE2[i]);
            rchk(aeqcfg_pkg::OFS_TRIM, TV[i] & 8'hBF);
        end
        chk("threshold mv", 9'h118, fast_threshold_mv);
        // every mode code; fast ignores trim and uses the short codes
        for (int m = 3; m >= 0; m--) begin
            wrs(aeqcfg_pkg::OFS_CTRL, {4'h8, 1'b0, m[1:0], 1'b1});
            chk("mode", {7'h00, m[1:0]}, {7'h00, adapt_mode_select});
            ceq((m == 0) ? 4'h5 : 4'h1, (m == 0) ? 4'h5 : 4'h4);
        end
        long_channel_detect = 2'h3;
        settle();
        ceq(4'h7, 4'h7);
        wrs(aeqcfg_pkg::OFS_LONG, 8'h3C);
        ceq(4'hC, 4'h3);
        rchk(aeqcfg_pkg::OFS_STAT2, 8'h80);
        long_channel_detect = 2'h1;
        settle();
        ceq(4'hC, 4'h5);
        rchk(aeqcfg_pkg::OFS_STAT2, 8'h00);
        // adaptation off: the connector register drives the receivers
        wrs(aeqcfg_pkg::OFS_CTRL, 8'h00);
        ceq(4'h5, 4'h5);
        rchk(aeqcfg_pkg::OFS_STAT1, 8'h00);
        wrs(aeqcfg_pkg::OFS_CONN, 8'h9E);
        rchk(aeqcfg_pkg::OFS_CONN, 8'h55);
        wrs(aeqcfg_pkg::OFS_GENERAL, 8'hFF);
        rchk(aeqcfg_pkg::OFS_GENERAL, 8'h10);
        u_aeqcfg_host_model.wr(aeqcfg_pkg::OFS_CONN, 8'h9E);
        wrs(aeqcfg_pkg::OFS_HOST, 8'h4B);
        rchk(aeqcfg_pkg::OFS_CONN, 8'h9E);
        ceq(4'hE, 4'h9);
        heq(4'hB, 4'h4);
        wrs(aeqcfg_pkg::OFS_GENERAL, 8'h00);
        rchk(aeqcfg_pkg::OFS_HOST, 8'hAA);
        heq(4'hA, 4'hA);
        ceq(4'h5, 4'h5);
        // idle redirect bit picks which low power state is entered
        idle_chk(1'b1, 1'b0);
        u_aeqcfg_host_model.wr(aeqcfg_pkg::OFS_CTRL, 8'h08);
        idle_chk(1'b0, 1'b1);
        final_report();
    end
endmodule

bind aeqcfg_regs aeqcfg_regs_sva u_aeqcfg_regs_sva (.clk(clk), .rst_n(rst_n),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .elec_idle_detect(elec_idle_detect),
    .long_channel_detect(long_channel_detect),
    .connector_receiver_1_eq(connector_receiver_1_eq),
    .connector_receiver_2_eq(connector_receiver_2_eq),
    .adapt_enable(adapt_enable),
    .adapt_mode_select(adapt_mode_select),
    .full_adapt_max_code(full_adapt_max_code),
    .fast_threshold_window(fast_threshold_window),
    .fast_threshold_mv(fast_threshold_mv), .enter_u1(enter_u1),
    .enter_u3(enter_u3));
